// file: serl_defines.vh
`ifndef SERL_DEFINES_VH
`define SERL_DEFINES_VH

// ----------------------------------------
// clock and link timing
// ----------------------------------------
`define SERL_CLK_PERIOD_NS   10
`define SERL_SCL_PERIOD_NS   10000
`define SERL_QTR_CYCLES      ((`SERL_SCL_PERIOD_NS / 4) / `SERL_CLK_PERIOD_NS)
`define SERL_PROBE_CYCLES    4'h8

// ----------------------------------------
// eeprom addressing and image layout
// ----------------------------------------
`define SERL_SLAVE_ADDR      7'h50
`define SERL_IMG_LAST        6'h24
`define SERL_IMG_WORDS       10
`define SERL_OFF_FUNC_IND    6'h00
`define SERL_OFF_COUNT       6'h01
`define SERL_OFF_CMD_F0      6'h02
`define SERL_OFF_CMD_F1      6'h03
`define SERL_OFF_SUBSYS      6'h04
`define SERL_OFF_LEGACY0     6'h08
`define SERL_OFF_SYSCTL_F0   6'h0c
`define SERL_OFF_SYSCTL_F1   6'h0d
`define SERL_OFF_SYSCTL_B2   6'h0f
`define SERL_OFF_RETRY       6'h15
`define SERL_OFF_CARDCTL     6'h16
`define SERL_OFF_DIAG        6'h18
`define SERL_OFF_GPOUT       6'h21
`define SERL_OFF_RSVD22      6'h22
`define SERL_OFF_LATGNT      6'h24
`define SERL_FUNC0_IND       8'h00
`define SERL_FUNC0_COUNT     8'h20
`define SERL_END_OF_LIST     8'h80

// ----------------------------------------
// bit masks of partially loaded bytes
// ----------------------------------------
`define SERL_MASK_CMD        8'he7
`define SERL_MASK_LEGACY0    8'hfe
`define SERL_MASK_SYSCTL_F0  8'h7f
`define SERL_MASK_SYSCTL_F1  8'h04
`define SERL_MASK_RETRY      8'hc0
`define SERL_MASK_CARDCTL    8'h80
`define SERL_MASK_DIAG       8'h9f
`define SERL_MASK_GPOUT      8'h1f
`define SERL_CFG_RESET       8'h00

// ----------------------------------------
// apb register map
// ----------------------------------------
`define SERL_REG_CTRL        12'h000
`define SERL_REG_STATUS      12'h004
`define SERL_REG_IMG_BASE    12'h040
`define SERL_CTRL_RELOAD     0
`define SERL_CTRL_HOLD       1
`define SERL_CTRL_RESET      2'h0

`endif

// file: serl_fifo.v
`timescale 1ns/1ps
`default_nettype none

module serl_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst,
    input  wire             flush,
    // fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_q;
    reg [AW-1:0]    rdPtr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    assign inReady  = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_q];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always @(posedge clock) begin
        if (rst || flush) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// file: serl_loader.v
`timescale 1ns/1ps
`default_nettype none
`include "serl_defines.vh"

module serl_loader (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // serial bus pins
    input  wire        sclIn,
    output wire        sclOut,
    output reg         sclOe,
    input  wire        sdaIn,
    output wire        sdaOut,
    output reg         sdaOe,
    // loaded defaults
    output wire [15:0] cmdFunc0,
    output wire [15:0] cmdFunc1,
    output wire [31:0] subsysId,
    output wire [7:0]  maxLatency,
    output wire [7:0]  minGrant,
    output wire        loadBusy,
    output wire        loadDone
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE   = 8'h01;
    localparam ST_START  = 8'h02;
    localparam ST_TXBIT  = 8'h04;
    localparam ST_TXACK  = 8'h08;
    localparam ST_RXBIT  = 8'h10;
    localparam ST_RXPUSH = 8'h20;
    localparam ST_RXACK  = 8'h40;
    localparam ST_STOP   = 8'h80;

    // ----------------------------------------
    // mask of loaded bits per image byte
    // ----------------------------------------
    function [7:0] loadMask;
        input [5:0] off;
        begin
            if (off == `SERL_OFF_CMD_F0 || off == `SERL_OFF_CMD_F1) begin
                loadMask = `SERL_MASK_CMD;
            end else if (off == `SERL_OFF_LEGACY0) begin
                loadMask = `SERL_MASK_LEGACY0;
            end else if (off == `SERL_OFF_SYSCTL_F0) begin
                loadMask = `SERL_MASK_SYSCTL_F0;
            end else if (off == `SERL_OFF_SYSCTL_F1) begin
                loadMask = `SERL_MASK_SYSCTL_F1;
            end else if (off == `SERL_OFF_RETRY) begin
                loadMask = `SERL_MASK_RETRY;
            end else if (off == `SERL_OFF_CARDCTL) begin
                loadMask = `SERL_MASK_CARDCTL;
            end else if (off == `SERL_OFF_DIAG) begin
                loadMask = `SERL_MASK_DIAG;
            end else if (off == `SERL_OFF_GPOUT) begin
                loadMask = `SERL_MASK_GPOUT;
            end else if (off == `SERL_OFF_RSVD22 || off == `SERL_OFF_SYSCTL_B2) begin
                loadMask = 8'h00;
            end else begin
                loadMask = 8'hff;
            end
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg        sclMeta_q;
    reg        sclSync_q;
    reg        sdaMeta_q;
    reg        sdaSync_q;

    always @(posedge clock) begin
        if (rst) begin
            sclMeta_q <= 1'b0;
            sclSync_q <= 1'b0;
            sdaMeta_q <= 1'b0;
            sdaSync_q <= 1'b0;
        end else begin
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
        end
    end

    // ----------------------------------------
    // control and status
    // ----------------------------------------
    reg [7:0]  state_q;
    reg [7:0]  qCnt_q;
    reg [1:0]  qIdx_q;
    reg [2:0]  bitCnt_q;
    reg [1:0]  seq_q;
    reg [1:0]  byteCnt_q;
    reg [7:0]  txByte_q;
    reg [7:0]  rxByte_q;
    reg [5:0]  wordAddr_q;
    reg        sdaBit_q;
    reg        abort_q;
    reg        present_q;
    reg [3:0]  probe_q;
    reg        autoGo_q;
    reg        busy_q;
    reg        done_q;
    reg        error_q;
    reg        endSeen_q;
    reg [1:0]  ctrl_q;
    wire [319:0] cfg_q;
    wire       reloadReq;
    wire       go;
    wire       qEnd;
    wire       opDone;
    wire       stretch;
    wire       lastWord;
    reg        sclLow;
    reg        sdaLow;

    assign stretch  = (qIdx_q == 2'h2) && !sclLow && !sclSync_q;
    assign qEnd     = (qCnt_q == `SERL_QTR_CYCLES - 1) && !stretch;
    assign opDone   = qEnd && (qIdx_q == 2'h3);
    assign lastWord = (wordAddr_q + 6'h04 > `SERL_IMG_LAST);
    assign go       = (autoGo_q || reloadReq) && (state_q == ST_IDLE) && sclSync_q;

    // ----------------------------------------
    // fifo between link and register writer
    // ----------------------------------------
    wire        fInReady;
    wire        fOutValid;
    wire        fOutReady;
    wire [13:0] fOutData;
    wire        pushReq;
    wire [5:0]  pushOff;

    assign pushReq   = (state_q == ST_RXPUSH);
    assign pushOff   = wordAddr_q + {4'h0, byteCnt_q};
    assign fOutReady = !ctrl_q[`SERL_CTRL_HOLD];

    serl_fifo #(
        .WIDTH (14),
        .DEPTH (8),
        .AW    (3)
    ) uFifo (
        .clock    (clock),
        .rst      (rst),
        .flush    (abort_q),
        .inValid  (pushReq),
        .inReady  (fInReady),
        .inData   ({pushOff, rxByte_q}),
        .outValid (fOutValid),
        .outReady (fOutReady),
        .outData  (fOutData)
    );

    // ----------------------------------------
    // pin levels per operation and quarter
    // ----------------------------------------
    always @* begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        case (state_q)
            ST_START: begin
                sdaLow = (qIdx_q >= 2'h2);
                sclLow = (qIdx_q == 2'h3);
            end
            ST_STOP: begin
                sdaLow = (qIdx_q != 2'h3);
                sclLow = (qIdx_q == 2'h0);
            end
            ST_TXBIT: begin
                sdaLow = !txByte_q[7];
                sclLow = (qIdx_q == 2'h0) || (qIdx_q == 2'h3);
            end
            ST_TXACK, ST_RXBIT: begin
                sclLow = (qIdx_q == 2'h0) || (qIdx_q == 2'h3);
            end
            ST_RXACK: begin
                sdaLow = (byteCnt_q != 2'h3);
                sclLow = (qIdx_q == 2'h0) || (qIdx_q == 2'h3);
            end
            ST_RXPUSH: begin
                sclLow = 1'b1;
            end
            default: begin
                sclLow = 1'b0;
            end
        endcase
    end

    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    // ----------------------------------------
    // link sequencer
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            qCnt_q     <= 8'h00;
            qIdx_q     <= 2'h0;
            bitCnt_q   <= 3'h0;
            seq_q      <= 2'h0;
            byteCnt_q  <= 2'h0;
            txByte_q   <= 8'h00;
            rxByte_q   <= 8'h00;
            wordAddr_q <= 6'h00;
            sdaBit_q   <= 1'b1;
            abort_q    <= 1'b0;
            probe_q    <= 4'h0;
            present_q  <= 1'b0;
            autoGo_q   <= 1'b0;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            error_q    <= 1'b0;
            sclOe      <= 1'b0;
            sdaOe      <= 1'b0;
        end else begin
            sclOe   <= sclLow;
            sdaOe   <= sdaLow;
            abort_q <= 1'b0;
            if (probe_q != `SERL_PROBE_CYCLES) begin
                probe_q <= probe_q + 4'h1;
                if (probe_q == `SERL_PROBE_CYCLES - 4'h1) begin
                    present_q <= sclSync_q;
                    autoGo_q  <= sclSync_q;
                end
            end
            if (state_q == ST_IDLE || state_q == ST_RXPUSH) begin
                qCnt_q <= 8'h00;
                qIdx_q <= 2'h0;
            end else if (qEnd) begin
                qCnt_q <= 8'h00;
                qIdx_q <= qIdx_q + 2'h1;
                if (qIdx_q == 2'h2) begin
                    sdaBit_q <= sdaSync_q;
                end
            end else if (!stretch) begin
                qCnt_q <= qCnt_q + 8'h01;
            end
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        autoGo_q   <= 1'b0;
                        busy_q     <= 1'b1;
                        done_q     <= 1'b0;
                        error_q    <= 1'b0;
                        wordAddr_q <= 6'h00;
                        seq_q      <= 2'h0;
                        state_q    <= ST_START;
                    end
                end
                ST_START: begin
                    if (opDone) begin
                        txByte_q <= {`SERL_SLAVE_ADDR, (seq_q == 2'h2)};
                        bitCnt_q <= 3'h7;
                        state_q  <= ST_TXBIT;
                    end
                end
                ST_TXBIT: begin
                    if (opDone) begin
                        txByte_q <= {txByte_q[6:0], 1'b1};
                        bitCnt_q <= bitCnt_q - 3'h1;
                        if (bitCnt_q == 3'h0) begin
                            state_q <= ST_TXACK;
                        end
                    end
                end
                ST_TXACK: begin
                    if (opDone) begin
                        if (sdaBit_q) begin
                            abort_q <= 1'b1;
                            error_q <= 1'b1;
                            state_q <= ST_STOP;
                        end else if (seq_q == 2'h0) begin
                            txByte_q <= {2'h0, wordAddr_q};
                            bitCnt_q <= 3'h7;
                            seq_q    <= 2'h1;
                            state_q  <= ST_TXBIT;
                        end else if (seq_q == 2'h1) begin
                            seq_q   <= 2'h2;
                            state_q <= ST_START;
                        end else begin
                            byteCnt_q <= 2'h0;
                            bitCnt_q  <= 3'h7;
                            state_q   <= ST_RXBIT;
                        end
                    end
                end
                ST_RXBIT: begin
                    if (opDone) begin
                        rxByte_q <= {rxByte_q[6:0], sdaBit_q};
                        bitCnt_q <= bitCnt_q - 3'h1;
                        if (bitCnt_q == 3'h0) begin
                            state_q <= ST_RXPUSH;
                        end
                    end
                end
                ST_RXPUSH: begin
                    if (fInReady) begin
                        state_q <= ST_RXACK;
                    end
                end
                ST_RXACK: begin
                    if (opDone) begin
                        bitCnt_q  <= 3'h7;
                        byteCnt_q <= byteCnt_q + 2'h1;
                        state_q   <= (byteCnt_q == 2'h3) ? ST_STOP : ST_RXBIT;
                    end
                end
                ST_STOP: begin
                    if (opDone) begin
                        if (error_q || endSeen_q || lastWord) begin
                            busy_q  <= 1'b0;
                            done_q  <= !error_q;
                            state_q <= ST_IDLE;
                        end else begin
                            wordAddr_q <= wordAddr_q + 6'h04;
                            seq_q      <= 2'h0;
                            state_q    <= ST_START;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // register writer
    // ----------------------------------------
    wire [5:0] popOff;
    wire [7:0] popByte;
    wire       popTake;
    wire       badHeader;

    assign popOff    = fOutData[13:8];
    assign popByte   = fOutData[7:0];
    assign popTake   = fOutValid && fOutReady && !endSeen_q && (popOff <= `SERL_IMG_LAST);
    assign badHeader = ((popOff == `SERL_OFF_FUNC_IND) && (popByte != `SERL_FUNC0_IND)) ||
                       ((popOff == `SERL_OFF_COUNT) && (popByte != `SERL_FUNC0_COUNT));

    always @(posedge clock) begin
        if (rst || go) begin
            endSeen_q <= 1'b0;
        end else if (popTake && badHeader) begin
            endSeen_q <= 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 40; gi = gi + 1) begin : gCfg
            wire [7:0] m = loadMask(gi[5:0]);
            reg  [7:0] byte_q;
            always @(posedge clock) begin
                if (rst || abort_q) begin
                    byte_q <= `SERL_CFG_RESET;
                end else if (popTake && !badHeader && popOff == gi[5:0]) begin
                    byte_q <= (popByte & m) | (byte_q & ~m);
                end
            end
            assign cfg_q[gi*8 +: 8] = byte_q;
        end
    endgenerate

    assign cmdFunc0   = {7'h00, cfg_q[23], 1'b0, cfg_q[22:21], 2'h0, cfg_q[18:16]};
    assign cmdFunc1   = {7'h00, cfg_q[31], 1'b0, cfg_q[30:29], 2'h0, cfg_q[26:24]};
    assign subsysId   = cfg_q[63:32];
    assign maxLatency = {4'h0, cfg_q[295:292]};
    assign minGrant   = {4'h0, cfg_q[291:288]};
    assign loadBusy   = busy_q;
    assign loadDone   = done_q;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    wire setup;
    wire wrAccess;
    wire [3:0] imgIdx;

    assign setup     = psel && !penable;
    assign wrAccess  = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign reloadReq = wrAccess && (paddr == `SERL_REG_CTRL) && pwdata[`SERL_CTRL_RELOAD];
    assign imgIdx    = paddr[5:2];

    always @(posedge clock) begin
        if (rst) begin
            ctrl_q  <= `SERL_CTRL_RESET;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            if (wrAccess && paddr == `SERL_REG_CTRL) begin
                ctrl_q <= {pwdata[`SERL_CTRL_HOLD], 1'b0};
            end
            if (setup) begin
                prdata  <= 32'h00000000;
                pslverr <= 1'b0;
                if (paddr == `SERL_REG_CTRL) begin
                    prdata <= {30'h0, ctrl_q};
                end else if (paddr == `SERL_REG_STATUS) begin
                    prdata <= {27'h0, endSeen_q, present_q, error_q, done_q, busy_q};
                end else if (paddr >= `SERL_REG_IMG_BASE && paddr[1:0] == 2'h0 && !pwrite &&
                             imgIdx < `SERL_IMG_WORDS && paddr[11:6] == 6'h01) begin
                    prdata <= cfg_q[imgIdx*32 +: 32];
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: serl_loader_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// loader checker
// ----------------------------------------
module serl_loader_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // bus pins
    input wire logic        sclIn,
    input wire logic        sclOe,
    input wire logic        sdaOe,
    // loaded defaults
    input wire logic [15:0] cmdFunc0,
    input wire logic [15:0] cmdFunc1,
    input wire logic [31:0] subsysId,
    input wire logic [7:0]  maxLatency,
    input wire logic [7:0]  minGrant,
    input wire logic        loadBusy,
    input wire logic        loadDone
);
    logic [9:0] lowCnt;
    logic [3:0] idleCnt;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // scl low time and idle time counters
    always_ff @(posedge clock) begin
        if (rst || !sclOe)
            lowCnt <= 10'h0;
        else if (lowCnt != 10'h3ff)
            lowCnt <= lowCnt + 10'h1;
        if (rst || loadBusy)
            idleCnt <= 4'h0;
        else if (idleCnt != 4'hf)
            idleCnt <= idleCnt + 4'h1;
    end

    auto_start_a: assert property ($fell(rst) && sclIn |-> ##[1:16] loadBusy)
        else $error("load did not start after reset");
    probe_scl_a: assert property ($rose(loadBusy) |-> $past(sclIn, 3))
        else $error("load started with scl low");
    cmd_bits_a: assert property (((cmdFunc0 | cmdFunc1) & 16'hfe98) == 16'h0)
        else $error("unmapped command bit set");
    idle_zero_a: assert property (!loadBusy && !loadDone |-> (cmdFunc0 | cmdFunc1) == 16'h0 && (maxLatency | minGrant) == 8'h00)
        else $error("defaults set without a finished load");
    cfg_quiet_a: assert property (idleCnt > 4'h4 |-> $stable(cmdFunc0) && $stable(subsysId) && $stable(minGrant))
        else $error("defaults changed while idle");
    abort_clear_a: assert property ($fell(loadBusy) |-> ##[0:3] (loadDone || (cmdFunc0 == 16'h0 && subsysId == 32'h0)))
        else $error("failed load left defaults");
    idle_bus_a: assert property (idleCnt > 4'h1 |-> !sclOe && !sdaOe)
        else $error("bus driven while idle");
    scl_low_a: assert property ($fell(sclOe) |-> lowCnt >= 10'd200)
        else $error("scl low phase too short");

    load_c: cover property ($rose(loadBusy));
    abort_c: cover property ($fell(loadBusy) && !loadDone);
    drive_c: cover property ($fell(sclOe));
endmodule

bind serl_loader serl_loader_chk chk (.clock(clock), .rst(rst), .sclIn(sclIn), .sclOe(sclOe), .sdaOe(sdaOe),
    .cmdFunc0(cmdFunc0), .cmdFunc1(cmdFunc1), .subsysId(subsysId), .maxLatency(maxLatency),
    .minGrant(minGrant), .loadBusy(loadBusy), .loadDone(loadDone));
`default_nettype wire

// file: serl_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "serl_defines.vh"
// ----------------------------------------
// serial eeprom model
// ----------------------------------------
module serl_eeprom_model (
    // bus lines
    input  wire logic       scl,
    input  wire logic       sda,
    // word address from which to refuse
    input  wire logic [7:0] nackFrom,
    // data line pull-down
    output var  logic       sdaLow
);
    logic [7:0] mem [0:63];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rd;
    logic       more;
    logic       fresh;
    logic       ph;
    int         bitN;
    int         hits;
    int         rdBytes;

    initial begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'h5a;
        mem[0] = 8'h00;
        mem[1] = 8'h20;
        mem[2] = 8'hff;
        mem[3] = 8'hb9;
        sdaLow = 1'b0;
        rd = 1'b0;
    end

    // start and stop
    always @(negedge sda) if (scl === 1'b1) begin
        bitN = 0;
        rd = 1'b0;
        ph = 1'b0;
        more = 1'b1;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        rd = 1'b0;
        bitN = 0;
    end

    always @(posedge scl) begin
        if (bitN < 8)
            sh = {sh[6:0], sda};
        else if (rd && !fresh) begin
            rdBytes++;
            if (sda)
                more = 1'b0;
        end
        bitN++;
    end

    always @(negedge scl) begin
        sdaLow = 1'b0;
        if (bitN == 8 && !rd) begin
            if (!ph) begin
                sdaLow = sh[7:1] == `SERL_SLAVE_ADDR;
                rd = sh[0] & sdaLow;
                fresh = 1'b1;
                hits += sdaLow;
            end else begin
                ptr = sh;
                sdaLow = sh < nackFrom;
            end
            ph = 1'b1;
        end else if (bitN == 9) begin
            bitN = 0;
            if (rd && more) begin
                ptr += !fresh;
                fresh = 1'b0;
                sdaLow = !mem[ptr[5:0]][7];
            end
        end else if (rd && more && bitN > 0 && bitN < 8)
            sdaLow = !mem[ptr[5:0]][7 - bitN];
    end
endmodule
`default_nettype wire

// file: serl_loader_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "serl_defines.vh"
module serl_loader_tb_top;
    logic        clock;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        sclGone;
    logic [7:0]  nackFrom;
    logic [31:0] rdv;
    logic        er;
    int          checks;
    int          n_fail;
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire         sclOe;
    wire         sdaOe;
    wire         sdaLow;
    wire         scl;
    wire         sda;
    wire  [15:0] cmdFunc0;
    wire  [15:0] cmdFunc1;
    wire  [31:0] subsysId;
    wire  [7:0]  maxLatency;
    wire  [7:0]  minGrant;
    wire         loadBusy;
    wire         loadDone;

    // open-drain lines with pull-ups
    assign scl = !(sclOe || sclGone);
    assign sda = !(sdaOe || sdaLow);

    serl_loader dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe),
        .cmdFunc0(cmdFunc0), .cmdFunc1(cmdFunc1), .subsysId(subsysId), .maxLatency(maxLatency),
        .minGrant(minGrant), .loadBusy(loadBusy), .loadDone(loadDone));
    serl_eeprom_model mdl (.scl(scl), .sda(sda), .nackFrom(nackFrom), .sdaLow(sdaLow));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task doReset;
        rst <= 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
    endtask

    task results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_absent;
        doReset();
        repeat (40) @(posedge clock);
        chk("busy", 32'h0, {31'h0, loadBusy});
        apb(1'b1, `SERL_REG_CTRL, 32'h1);
        repeat (20) @(posedge clock);
        chk("busy", 32'h0, {31'h0, loadBusy});
        apb(1'b0, `SERL_REG_STATUS, 32'h0);
        chk("status", 32'h0, rdv & 32'h1f);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b1, `SERL_REG_IMG_BASE, 32'h1);
        chk("image write err", 32'h1, {31'h0, er});
    endtask

    task t_load;
        int i;
        sclGone <= 1'b0;
        doReset();
        apb(1'b1, `SERL_REG_CTRL, 32'h2);
        for (i = 0; i < 20 && !loadBusy; i++)
            @(posedge clock);
        chk("busy", 32'h1, {31'h0, loadBusy});
        for (i = 0; i < 80000 && mdl.rdBytes < 4; i++)
            @(posedge clock);
        repeat (300) @(posedge clock);
        chk("cmd held", 32'h0, {16'h0, cmdFunc0});
        apb(1'b1, `SERL_REG_CTRL, 32'h0);
        repeat (20) @(posedge clock);
        chk("cmd f0", 32'h167, {16'h0, cmdFunc0});
        chk("cmd f1", 32'h121, {16'h0, cmdFunc1});
        apb(1'b0, `SERL_REG_IMG_BASE, 32'h0);
        chk("image 0", 32'ha1e72000, rdv);
        chk("addr hits", 32'h2, mdl.hits);
        for (i = 0; i < 30000 && loadBusy; i++)
            @(posedge clock);
        repeat (4) @(posedge clock);
        chk("cmd f0", 32'h0, {16'h0, cmdFunc0});
        chk("subsys", 32'h0, subsysId);
        chk("latgnt", 32'h0, {16'h0, maxLatency, minGrant});
        apb(1'b0, `SERL_REG_STATUS, 32'h0);
        chk("status", 32'hc, rdv & 32'hf);
        apb(1'b0, `SERL_REG_IMG_BASE, 32'h0);
        chk("image 0", 32'h0, rdv);
    endtask

    // ----------------------------------------
    // clock, sequence, watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        {psel, penable, pwrite} = 3'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rst = 1'b1;
        sclGone = 1'b1;
        nackFrom = 8'h04;
        t_absent();
        t_load();
        results();
    end

    initial begin
        repeat (95000) @(posedge clock);
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
